// File: include/cfg_loader_pkg.sv
// Constants, field layouts and types shared by the configuration word loader
//
// Behaviour
// [R01] After reset, fetch every load word and copy its fields; other word bits ignored.
// [R02] Word 44h bits 15:14 go to port 2 offset 8Ch bits 9:8.
// [R03] Word 50h bit 0 goes to port 0 offset 44h bit 3.
// [R04] Word 50h bits 3:1 go to port 0 offset 40h bits 24:22.
// [R05] Word 50h bit 4 to 40h bit 25, bit 5 to bit 26.
// [R06] Power word bits 7:6 go to offset 40h bits 29:28.
// [R07] Word 51h bits 15:8 go to port 0 offset 44h bits 31:24.
// [R08] Port 1 uses words 52h/53h, port 2 words 54h/55h, same layout.
// [R09] Slot word bit 1 goes to offset D0h bit 28.
// [R10] Word 60h bit 2 goes to port 0 offset 40h bit 21.
// [R11] Word 60h bit 3 goes to port 0 offset port_vc_capability_word bit 4.
// [R12] Word 60h bits 6:4 go to port 0 offset Link_capability_word bits 26:24.
// [R13] Word 60h bits 15:9 go to port 0 offset vc0_resource_capability bits 7:1.
// [R14] Word 62h bit 0 goes to port 1 offset C0h bit 24.
// [R15] Word 62h fills port 1 slot fields at port 0 bit positions.
// [R16] Port 2 slot word bit 0 goes to port 2 offset C0h bit 24.
package cfg_loader_pkg;

  // Word addresses in the configuration store
  localparam logic [7:0] WORD_P2_PHY    = 8'h44;
  localparam logic [7:0] WORD_P0_POWER  = 8'h50;
  localparam logic [7:0] WORD_P0_PMDATA = 8'h51;
  localparam logic [7:0] WORD_P1_POWER  = 8'h52;
  localparam logic [7:0] WORD_P1_PMDATA = 8'h53;
  localparam logic [7:0] WORD_P2_POWER  = 8'h54;
  localparam logic [7:0] WORD_P2_PMDATA = 8'h55;
  localparam logic [7:0] WORD_P0_SLOT   = 8'h60;
  localparam logic [7:0] WORD_P1_SLOT   = 8'h62;
  localparam logic [7:0] WORD_P2_SLOT   = 8'h64;

  localparam int LOAD_COUNT = 10;
  localparam logic [LOAD_COUNT-1:0][7:0] LOAD_ORDER = {
    WORD_P2_SLOT, WORD_P1_SLOT, WORD_P0_SLOT,
    WORD_P2_PMDATA, WORD_P2_POWER, WORD_P1_PMDATA, WORD_P1_POWER,
    WORD_P0_PMDATA, WORD_P0_POWER, WORD_P2_PHY};

  // Configuration-space offsets per port
  localparam logic [11:0] OFS_PM_CAP      = 12'h0040;
  localparam logic [11:0] OFS_PM_CSR      = 12'h0044;
  localparam logic [11:0] OFS_PHY_COUNT   = 12'h008c;
  localparam logic [11:0] OFS_EXP_CAP     = 12'h00c0;
  localparam logic [11:0] OFS_LINK_CAP    = 12'h00cc;
  localparam logic [11:0] OFS_LINK_STATUS = 12'h00d0;
  localparam logic [11:0] OFS_PORT_VC_CAP = 12'h0144;
  localparam logic [11:0] OFS_VC0_RES_CAP = 12'h0154;

  // Field positions inside the configuration words (low bit)
  localparam int POS_DSI        = 21;
  localparam int POS_AUX        = 22;
  localparam int POS_D1         = 25;
  localparam int POS_D2         = 26;
  localparam int POS_PWR_EVENT  = 28;
  localparam int POS_NO_SRST    = 3;
  localparam int POS_PM_DATA    = 24;
  localparam int POS_PHY_COUNT  = 8;
  localparam int POS_SLOT_IMPL  = 24;
  localparam int POS_PORT_NUM   = 24;
  localparam int POS_SLOT_CLOCK = 28;
  localparam int POS_LP_COUNT   = 4;
  localparam int POS_TC_MAP     = 1;

  // Field positions inside a load word (low bit)
  localparam int LW_NO_SRST    = 0;
  localparam int LW_AUX        = 1;
  localparam int LW_D1         = 4;
  localparam int LW_D2         = 5;
  localparam int LW_PWR_EVENT  = 6;
  localparam int LW_PM_DATA    = 8;
  localparam int LW_PHY_COUNT  = 14;
  localparam int LW_SLOT_IMPL  = 0;
  localparam int LW_SLOT_CLOCK = 1;
  localparam int LW_DSI        = 2;
  localparam int LW_LP_COUNT   = 3;
  localparam int LW_PORT_NUM   = 4;
  localparam int LW_TC_MAP     = 9;

  typedef struct packed {
    logic [1:0] phy_change_count_select;
    logic       no_soft_reset;
    logic [2:0] aux_current;
    logic       d1_support;
    logic       d2_support;
    logic [1:0] power_event_signal;
    logic [7:0] pm_data;
    logic       slot_clock;
    logic       dsi_required;
    logic       low_priority_channel_count;
    logic [2:0] port_number;
    logic [6:0] tc_map;
    logic       slot_implemented;
  } port_cfg_t;

  localparam port_cfg_t PORT_CFG_RESET = '0;

  typedef enum logic [1:0] {
    ST_FETCH = 2'b00,
    ST_DONE  = 2'b01
  } load_state_t;

  typedef struct packed {
    load_state_t          state;
    logic [3:0]           idx;
    logic [7:0]           store_addr;
    logic [2:0][$bits(port_cfg_t)-1:0] cfg;
    logic [31:0]          cfg_rdata;
    logic                 cfg_rvalid;
  } loader_state_t;

endpackage

// File: logic/cfg_word_loader.sv
// Loader that copies store words into per-port configuration fields
`timescale 1ns/1ps

module cfg_word_loader (
  input  wire logic                                ref_clk,
  input  wire logic                                reset,
  output logic                                     store_req,
  output logic [7:0]                               store_addr,
  input  wire logic                                store_ack,
  input  wire logic [15:0]                         store_data,
  output logic                                     load_done,
  input  wire logic                                cfg_read,
  input  wire logic [1:0]                          cfg_port,
  input  wire logic [11:0]                         cfg_offset,
  output logic                                     cfg_rvalid,
  output logic [31:0]                              cfg_rdata,
  output cfg_loader_pkg::port_cfg_t [2:0]          port_cfg
);

  cfg_loader_pkg::loader_state_t state_reg;
  cfg_loader_pkg::loader_state_t state_next;

  // Fold one power-management word into a port
  function automatic cfg_loader_pkg::port_cfg_t apply_power(
    input cfg_loader_pkg::port_cfg_t cur,
    input logic [15:0]               d
  );
    cfg_loader_pkg::port_cfg_t res;
    res = cur;
    res.no_soft_reset      = d[cfg_loader_pkg::LW_NO_SRST];        // [R03] [R08]
    res.aux_current        = d[cfg_loader_pkg::LW_AUX +: 3];       // [R04] [R08]
    res.d1_support         = d[cfg_loader_pkg::LW_D1];             // [R05]
    res.d2_support         = d[cfg_loader_pkg::LW_D2];             // [R05]
    res.power_event_signal = d[cfg_loader_pkg::LW_PWR_EVENT +: 2]; // [R06]
    return res;
  endfunction

  // Fold one slot word into a port; port 0 has no slot-implemented bit here
  function automatic cfg_loader_pkg::port_cfg_t apply_slot(
    input cfg_loader_pkg::port_cfg_t cur,
    input logic [15:0]               d,
    input logic                      has_slot_bit
  );
    cfg_loader_pkg::port_cfg_t res;
    res = cur;
    res.slot_clock                 = d[cfg_loader_pkg::LW_SLOT_CLOCK];  // [R09] [R15]
    res.dsi_required               = d[cfg_loader_pkg::LW_DSI];         // [R10] [R15]
    res.low_priority_channel_count = d[cfg_loader_pkg::LW_LP_COUNT];    // [R11] [R15]
    res.port_number                = d[cfg_loader_pkg::LW_PORT_NUM +: 3]; // [R12] [R15]
    res.tc_map                     = d[cfg_loader_pkg::LW_TC_MAP +: 7]; // [R13]
    if (has_slot_bit) begin
      res.slot_implemented = d[cfg_loader_pkg::LW_SLOT_IMPL];          // [R14] [R16]
    end
    return res;
  endfunction

  // Read view of one configuration offset of one port; unmapped bits read zero
  function automatic logic [31:0] cfg_view(
    input cfg_loader_pkg::port_cfg_t c,
    input logic [11:0]               ofs
  );
    logic [31:0] v;
    v = 32'h0000_0000;
    case (ofs)
      cfg_loader_pkg::OFS_PM_CAP: begin
        v[cfg_loader_pkg::POS_DSI]             = c.dsi_required;
        v[cfg_loader_pkg::POS_AUX +: 3]        = c.aux_current;
        v[cfg_loader_pkg::POS_D1]              = c.d1_support;
        v[cfg_loader_pkg::POS_D2]              = c.d2_support;
        v[cfg_loader_pkg::POS_PWR_EVENT +: 2]  = c.power_event_signal;
      end
      cfg_loader_pkg::OFS_PM_CSR: begin
        v[cfg_loader_pkg::POS_NO_SRST]         = c.no_soft_reset;
        v[cfg_loader_pkg::POS_PM_DATA +: 8]    = c.pm_data;
      end
      cfg_loader_pkg::OFS_PHY_COUNT: begin
        v[cfg_loader_pkg::POS_PHY_COUNT +: 2]  = c.phy_change_count_select;
      end
      cfg_loader_pkg::OFS_EXP_CAP: begin
        v[cfg_loader_pkg::POS_SLOT_IMPL]       = c.slot_implemented;
      end
      cfg_loader_pkg::OFS_LINK_CAP: begin
        v[cfg_loader_pkg::POS_PORT_NUM +: 3]   = c.port_number;
      end
      cfg_loader_pkg::OFS_LINK_STATUS: begin
        v[cfg_loader_pkg::POS_SLOT_CLOCK]      = c.slot_clock;
      end
      cfg_loader_pkg::OFS_PORT_VC_CAP: begin
        v[cfg_loader_pkg::POS_LP_COUNT]        = c.low_priority_channel_count;
      end
      cfg_loader_pkg::OFS_VC0_RES_CAP: begin
        v[cfg_loader_pkg::POS_TC_MAP +: 7]     = c.tc_map;
      end
      default: begin
        v = 32'h0000_0000;
      end
    endcase
    return v;
  endfunction

  cfg_loader_pkg::port_cfg_t [2:0] cur_cfg;
  cfg_loader_pkg::port_cfg_t [2:0] new_cfg;
  logic [7:0]                      cur_word;
  logic                            last_word;

  assign cur_cfg   = state_reg.cfg;
  assign cur_word  = cfg_loader_pkg::LOAD_ORDER[state_reg.idx];
  assign last_word = (state_reg.idx == 4'(cfg_loader_pkg::LOAD_COUNT - 1));

  // Decode the word just returned by the store into the port fields
  always_comb begin
    new_cfg = cur_cfg;
    case (cur_word)
      cfg_loader_pkg::WORD_P2_PHY: begin
        new_cfg[2].phy_change_count_select =
          store_data[cfg_loader_pkg::LW_PHY_COUNT +: 2];                // [R02]
      end
      cfg_loader_pkg::WORD_P0_POWER: begin
        new_cfg[0] = apply_power(cur_cfg[0], store_data);
      end
      cfg_loader_pkg::WORD_P1_POWER: begin
        new_cfg[1] = apply_power(cur_cfg[1], store_data);                // [R08]
      end
      cfg_loader_pkg::WORD_P2_POWER: begin
        new_cfg[2] = apply_power(cur_cfg[2], store_data);                // [R08]
      end
      cfg_loader_pkg::WORD_P0_PMDATA: begin
        new_cfg[0].pm_data = store_data[cfg_loader_pkg::LW_PM_DATA +: 8]; // [R07]
      end
      cfg_loader_pkg::WORD_P1_PMDATA: begin
        new_cfg[1].pm_data = store_data[cfg_loader_pkg::LW_PM_DATA +: 8]; // [R08]
      end
      cfg_loader_pkg::WORD_P2_PMDATA: begin
        new_cfg[2].pm_data = store_data[cfg_loader_pkg::LW_PM_DATA +: 8]; // [R08]
      end
      cfg_loader_pkg::WORD_P0_SLOT: begin
        new_cfg[0] = apply_slot(cur_cfg[0], store_data, 1'h0);
      end
      cfg_loader_pkg::WORD_P1_SLOT: begin
        new_cfg[1] = apply_slot(cur_cfg[1], store_data, 1'h1);           // [R14] [R15]
      end
      cfg_loader_pkg::WORD_P2_SLOT: begin
        new_cfg[2] = apply_slot(cur_cfg[2], store_data, 1'h1);           // [R16]
      end
      default: begin
        new_cfg = cur_cfg;
      end
    endcase
  end

  // Next-state logic for the whole module
  always_comb begin
    state_next            = state_reg;
    state_next.cfg_rvalid = 1'b0;
    case (state_reg.state)
      cfg_loader_pkg::ST_FETCH: begin
        // Words are requested one at a time, in a fixed order, right after reset
        state_next.store_addr = cur_word;                               // [R01]
        if (store_ack) begin
          state_next.cfg = new_cfg;                                     // [R01]
          if (last_word) begin
            state_next.state = cfg_loader_pkg::ST_DONE;
          end else begin
            state_next.idx        = state_reg.idx + 4'h1;
            state_next.store_addr = cfg_loader_pkg::LOAD_ORDER[state_reg.idx + 4'h1];
          end
        end
      end
      cfg_loader_pkg::ST_DONE: begin
        state_next.state = cfg_loader_pkg::ST_DONE;
      end
      default: begin
        state_next.state = cfg_loader_pkg::ST_FETCH;
      end
    endcase
    // Reads are answered even during the load; they then show partial contents
    if (cfg_read) begin
      state_next.cfg_rvalid = 1'b1;
      if (cfg_port == 2'h3) begin
        state_next.cfg_rdata = 32'h0000_0000;
      end else begin
        state_next.cfg_rdata = cfg_view(cur_cfg[cfg_port], cfg_offset);
      end
    end
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_reg.state      <= cfg_loader_pkg::ST_FETCH;
      state_reg.idx        <= 4'h0;
      state_reg.store_addr <= cfg_loader_pkg::LOAD_ORDER[0];
      state_reg.cfg        <= {3{cfg_loader_pkg::PORT_CFG_RESET}};
      state_reg.cfg_rdata  <= 32'h0000_0000;
      state_reg.cfg_rvalid <= 1'b0;
    end else begin
      state_reg <= state_next;
    end
  end

  // The request is a handshake level; the address behind it is registered
  assign store_req  = (state_reg.state == cfg_loader_pkg::ST_FETCH) && !reset;
  assign store_addr = state_reg.store_addr;
  assign load_done  = (state_reg.state == cfg_loader_pkg::ST_DONE);
  assign cfg_rvalid = state_reg.cfg_rvalid;
  assign cfg_rdata  = state_reg.cfg_rdata;
  assign port_cfg   = cur_cfg;

endmodule

// File: testbench/cfg_loader_properties.sv
// Port checker for the configuration word loader
`timescale 1ns/1ps

module cfg_loader_properties (
  input wire logic                            ref_clk,
  input wire logic                            reset,
  input wire logic                            store_req,
  input wire logic [7:0]                      store_addr,
  input wire logic                            store_ack,
  input wire logic [15:0]                     store_data,
  input wire logic                            load_done,
  input wire logic                            cfg_read,
  input wire logic [1:0]                      cfg_port,
  input wire logic [31:0]                     cfg_rdata,
  input wire logic                            cfg_rvalid,
  input wire cfg_loader_pkg::port_cfg_t [2:0] port_cfg
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);
  wire take = store_req && store_ack;

  chk_idle_reset: assert property (disable iff (1'h0) reset |-> !store_req)
    else $error("store request during reset");
  chk_first_word: assert property (disable iff (1'h0) reset |=> store_addr == 8'h44)
    else $error("first word address wrong");
  chk_addr_hold: assert property (store_req && !store_ack |=> $stable(store_addr))
    else $error("word address moved without ack");
  chk_phy_copy: assert property (take && store_addr == 8'h44 |=>
    port_cfg[2].phy_change_count_select == 2'($past(store_data) >> 14))
    else $error("change select not copied");
  chk_aux_copy: assert property (take && store_addr == 8'h50 |=>
    port_cfg[0].aux_current == 3'($past(store_data) >> 1)) else $error("aux current wrong");
  chk_data_copy: assert property (take && store_addr == 8'h55 |=>
    port_cfg[2].pm_data == 8'($past(store_data) >> 8)) else $error("port 2 data wrong");
  chk_slot_step: assert property (take && store_addr == 8'h60 |=> store_addr == 8'h62)
    else $error("slot word order wrong");
  chk_load_end: assert property (take && store_addr == 8'h64 |=> load_done && !store_req)
    else $error("load did not end after last word");
  chk_read_pulse: assert property (1'h1 |=> cfg_rvalid == $past(cfg_read))
    else $error("read answer not one cycle after request");
  chk_port_none: assert property (cfg_read && cfg_port == 2'h3 |=> cfg_rdata == 32'h0000_0000)
    else $error("absent port reads nonzero");

  cover property (take && store_addr == 8'h64);
  cover property (store_req && !store_ack);
  cover property (cfg_read && cfg_port == 2'h3);
  cover property (cfg_rvalid && load_done);
endmodule

bind cfg_word_loader cfg_loader_properties chk (.ref_clk(ref_clk), .reset(reset),
  .store_req(store_req), .store_addr(store_addr), .store_ack(store_ack),
  .store_data(store_data), .load_done(load_done), .cfg_read(cfg_read), .cfg_port(cfg_port),
  .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid), .port_cfg(port_cfg));

// File: testbench/cfg_store_model.sv
// Behavioural configuration store that answers word requests
`timescale 1ns/1ps

module cfg_store_model (
  input  wire logic        ref_clk,
  input  wire logic        store_req,
  input  wire logic [7:0]  store_addr,
  output logic             store_ack,
  output logic [15:0]      store_data
);
  logic [15:0] mem [256];
  logic [15:0] last_reg = 16'h0000;
  logic        go_reg   = 1'h0;

  // Random stalls, so words arrive back to back as well as after waits
  always @(posedge ref_clk) begin
    go_reg <= ($urandom_range(0, 2) != 0);
    if (store_ack)
      last_reg <= store_data;
  end
  assign store_ack  = go_reg && store_req;
  // An idle data bus shows the inverse of the last word, never a stale copy
  assign store_data = store_ack ? mem[store_addr] : ~last_reg;
endmodule

// File: testbench/tb_eeprom_pm_slot_config_loader.sv
// Self-checking bench for the configuration word loader
`timescale 1ns/1ps

module tb_eeprom_pm_slot_config_loader;
  logic                            ref_clk    = 1'h0;
  logic                            reset      = 1'h1;
  logic                            cfg_read   = 1'h0;
  logic [1:0]                      cfg_port   = 2'h0;
  logic [11:0]                     cfg_offset = 12'h0000;
  logic                            store_req, store_ack, load_done, cfg_rvalid;
  logic [7:0]                      store_addr;
  logic [15:0]                     store_data;
  logic [31:0]                     cfg_rdata;
  cfg_loader_pkg::port_cfg_t [2:0] port_cfg;
  logic [31:0]                     exp_q[$];
  string                           name_q[$];
  int                              bad_count  = 0;
  int                              tests_run  = 0;

  always #5 ref_clk = ~ref_clk;

  cfg_word_loader DUT (.ref_clk(ref_clk), .reset(reset), .store_req(store_req),
    .store_addr(store_addr), .store_ack(store_ack), .store_data(store_data),
    .load_done(load_done), .cfg_read(cfg_read), .cfg_port(cfg_port), .cfg_offset(cfg_offset),
    .cfg_rvalid(cfg_rvalid), .cfg_rdata(cfg_rdata), .port_cfg(port_cfg));
  cfg_store_model store (.ref_clk(ref_clk), .store_req(store_req), .store_addr(store_addr),
    .store_ack(store_ack), .store_data(store_data));

  function automatic logic [31:0] expect_word(int p, logic [11:0] o);
    logic [15:0] w;
    logic [15:0] d;
    logic [15:0] s;
    w = store.mem[8'h50 + 2 * p];
    d = store.mem[8'h51 + 2 * p];
    s = store.mem[8'h60 + 2 * p];
    if (p == 3)
      return 32'h0000_0000;
    case (o)
      12'h0040: return {2'h0, w[7:6], 1'h0, w[5], w[4], w[3:1], s[2], 21'h0};
      12'h0044: return {d[15:8], 20'h0, w[0], 3'h0};
      12'h008c: return {22'h0, p == 2 ? store.mem[8'h44][15:14] : 2'h0, 8'h0};
      12'h00c0: return {7'h0, p != 0 && s[0], 24'h0};
      12'h00cc: return {5'h0, s[6:4], 24'h0};
      12'h00d0: return {3'h0, s[1], 28'h0};
      12'h0144: return {27'h0, s[3], 4'h0};
      12'h0154: return {24'h0, s[15:9], 1'h0};
      default: return 32'h0000_0000;
    endcase
  endfunction

  task automatic check(string name, logic [31:0] exp, logic [31:0] got);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask

  // Strobe stays high across calls, so reads go back to back
  task automatic rd(int p, logic [11:0] o);
    @(negedge ref_clk);
    cfg_read = 1'h1;
    cfg_port = 2'(p);
    cfg_offset = o;
    exp_q.push_back(expect_word(p, o));
    name_q.push_back($sformatf("port %0d offset %h", p, o));
  endtask

  task automatic close_out();
    $display("Comparisons %0d, mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  always @(negedge ref_clk) begin
    if (!reset && cfg_rvalid === 1'h1) begin
      if (exp_q.size() == 0) begin
        bad_count++;
        $display("[ERR] read answer expected none seen %h", cfg_rdata);
      end else begin
        check(name_q.pop_front(), exp_q.pop_front(), cfg_rdata);
      end
    end
  end

  initial begin
    void'($urandom(96));
    foreach (store.mem[i])
      store.mem[i] = 16'($urandom);
    repeat (5) @(negedge ref_clk);
    reset = 1'h0;
    for (int run = 0; run < 2; run++) begin
      for (int n = 0; n < 400 && load_done !== 1'h1; n++)
        @(negedge ref_clk);
      check("load_done", 32'h1, 32'(load_done));
      check("store_req after load", 32'h0, 32'(store_req));
      for (int p = 0; p < 4; p++) begin
        rd(p, 12'h0040);
        rd(p, 12'h0044);
        rd(p, 12'h008c);
        rd(p, 12'h00c0);
        rd(p, 12'h00cc);
        rd(p, 12'h00d0);
        rd(p, 12'h0144);
        rd(p, 12'h0154);
        rd(p, 12'h0048);
      end
      @(negedge ref_clk);
      cfg_read = 1'h0;
      repeat (3) @(negedge ref_clk);
      check("pending answers", 32'h0, 32'(exp_q.size()));
      // Inverted image flips every field; a reset cuts the next load short
      foreach (store.mem[i])
        store.mem[i] = ~store.mem[i];
      reset = 1'h1;
      @(negedge ref_clk);
      reset = 1'h0;
      repeat (4) @(negedge ref_clk);
      reset = 1'h1;
      @(negedge ref_clk);
      reset = 1'h0;
    end
    close_out();
  end

  initial begin
    repeat (20000) @(posedge ref_clk);
    bad_count++;
    $display("[ERR] run expected finish seen timeout");
    close_out();
  end
endmodule
